/* File: src/ioo_pkg.sv */
// Constants and types shared by the indexed offset operand decoder
`default_nettype none
package ioo_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0]  SFP_OFFSET    = 8'h00;
  localparam logic [7:0]  BANK_OFFSET   = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET = 8'h08;
  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam int          BANK_W        = 4;
  localparam int          FILE_W        = 8;
  localparam int          STAT_EXT_BIT  = 0;
  localparam int          STAT_RUN_BIT  = 1;
  localparam int          STAT_IDX_BIT  = 2;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] SFP_RESET     = 12'h000;
  localparam logic [3:0]  BANK_RESET    = 4'h0;
  // ----------------------------------------------------------------
  // Address map of the access bank and offset window
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFFSET_LIMIT  = 8'h5f;
  localparam logic [3:0]  LOW_ACC_BANK  = 4'h0;
  localparam logic [3:0]  HIGH_ACC_BANK = 4'hf;
  // ----------------------------------------------------------------
  // Timing: clocks for the configuration synchroniser to settle
  // ----------------------------------------------------------------
  localparam logic [1:0]  SETTLE_COUNT  = 2'h3;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b01,
    ST_RUN    = 2'b10
  } ioo_state_t;
endpackage : ioo_pkg
`default_nettype wire

/* File: src/ioo_addr_calc.sv */
// Combinational operand address former: literal or indexed offset
`default_nettype none
module ioo_addr_calc (
  input  wire logic [7:0]  file_field,
  input  wire logic        access_bit,
  input  wire logic        ext_en,
  input  wire logic [11:0] sfp,
  input  wire logic [3:0]  bank,
  output logic      [11:0] data_addr,
  output logic             indexed
);
  logic low_half;

  always_comb begin
    low_half  = (file_field <= ioo_pkg::OFFSET_LIMIT);
    // Same test for every byte and bit opcode carrying the access bit
    indexed   = ext_en && !access_bit && low_half;
    if (indexed) begin
      // Offset from stack frame pointer; zero pointer maps to bank 0
      data_addr = sfp + {4'h0, file_field};
    end else if (access_bit) begin
      data_addr = {bank, file_field};
    end else if (low_half) begin
      data_addr = {ioo_pkg::LOW_ACC_BANK, file_field};
    end else begin
      // Upper access bank stays literal in both modes
      data_addr = {ioo_pkg::HIGH_ACC_BANK, file_field};
    end
  end
endmodule : ioo_addr_calc
`default_nettype wire

/* File: src/ioo_operand_decode.sv */
// Operand address decode for byte and bit instructions, Wishbone slave
// Notes on behaviour
// - Extension off: file field is literal, access bank or bank register.
// - Extension on, access bit 0, field up to 5Fh: pointer plus field.
// - Fields above 5Fh with access bit 0 always address the access bank literally.
// - Indexed interpretation covers every byte and bit opcode alike.
// - Pointer 00h gives the same locations as plain access bank.
// - Destination bit keeps its usual meaning in indexed mode.
// - Destination 0 writes working register, 1 writes the file register.
`default_nettype none
module ioo_operand_decode (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CFG_EXT_EN,
  input  wire logic        DEC_VALID,
  input  wire logic [7:0]  DEC_FILE,
  input  wire logic        DEC_ACCESS,
  input  wire logic        DEC_DEST,
  output logic             ADDR_VALID,
  output logic      [11:0] DATA_ADDR,
  output logic             INDEXED,
  output logic             DEST_W,
  output logic             DEST_FILE,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O
);
  typedef struct packed {
    logic                 cfg_s1;
    logic                 cfg_s2;
    logic                 cfg_s3;
    logic [1:0]           settle;
    ioo_pkg::ioo_state_t  state;
    logic                 ext_en;
    logic [11:0]          sfp;
    logic [3:0]           bank;
    logic                 ack;
    logic [31:0]          rdata;
    logic                 addr_valid;
    logic [11:0]          data_addr;
    logic                 indexed;
    logic                 dest_w;
    logic                 dest_file;
  } ioo_regs_t;

  ioo_regs_t   r_reg;
  ioo_regs_t   r_next;
  logic [11:0] calc_addr;
  logic        calc_indexed;
  logic        bus_req;

  // ----------------------------------------------------------------
  // Register select
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_sel(input logic [7:0] adr);
    reg_sel = 3'h0;
    unique case (adr)
      ioo_pkg::SFP_OFFSET:    reg_sel = 3'h1;
      ioo_pkg::BANK_OFFSET:   reg_sel = 3'h2;
      ioo_pkg::STATUS_OFFSET: reg_sel = 3'h4;
      default:                reg_sel = 3'h0;
    endcase
  endfunction : reg_sel

  ioo_addr_calc u_calc (
    .file_field (DEC_FILE),
    .access_bit (DEC_ACCESS),
    .ext_en     (r_reg.ext_en),
    .sfp        (r_reg.sfp),
    .bank       (r_reg.bank),
    .data_addr  (calc_addr),
    .indexed    (calc_indexed)
  );

  assign bus_req = WB_CYC_I && WB_STB_I && !r_reg.ack;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next        = r_reg;
    // Configuration pin synchroniser
    r_next.cfg_s1 = CFG_EXT_EN;
    r_next.cfg_s2 = r_reg.cfg_s1;
    r_next.cfg_s3 = r_reg.cfg_s2;
    unique case (r_reg.state)
      ioo_pkg::ST_SETTLE: begin
        if (r_reg.settle == ioo_pkg::SETTLE_COUNT &&
            r_reg.cfg_s2 == r_reg.cfg_s3) begin
          // Captured once; held until the next reset
          r_next.ext_en = r_reg.cfg_s3;
          r_next.state  = ioo_pkg::ST_RUN;
        end else if (r_reg.settle != ioo_pkg::SETTLE_COUNT) begin
          r_next.settle = r_reg.settle + 2'h1;
        end
      end
      ioo_pkg::ST_RUN: begin
        r_next.state = ioo_pkg::ST_RUN;
      end
      default: begin
        r_next.state = ioo_pkg::ST_SETTLE;
      end
    endcase
    // Decode path, one cycle of latency
    r_next.addr_valid = DEC_VALID && (r_reg.state == ioo_pkg::ST_RUN);
    if (DEC_VALID) begin
      r_next.data_addr = calc_addr;
      r_next.indexed   = calc_indexed;
      r_next.dest_file = DEC_DEST;
      r_next.dest_w    = !DEC_DEST;
    end
    // Wishbone slave: ack one cycle after the request is seen
    r_next.ack   = bus_req;
    r_next.rdata = 32'h0000_0000;
    // Writes land at the edge where the master samples ack high
    if (WB_CYC_I && WB_STB_I && WB_WE_I && r_reg.ack) begin
      unique case (reg_sel(WB_ADR_I))
        3'h1: begin
          if (WB_SEL_I[0]) begin
            r_next.sfp[7:0] = WB_DAT_I[7:0];
          end
          if (WB_SEL_I[1]) begin
            r_next.sfp[11:8] = WB_DAT_I[11:8];
          end
        end
        3'h2: begin
          if (WB_SEL_I[0]) begin
            r_next.bank = WB_DAT_I[3:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (bus_req && !WB_WE_I) begin
      unique case (reg_sel(WB_ADR_I))
        3'h1: r_next.rdata = {20'h00000, r_reg.sfp};
        3'h2: r_next.rdata = {28'h0000000, r_reg.bank};
        3'h4: begin
          r_next.rdata[ioo_pkg::STAT_EXT_BIT] = r_reg.ext_en;
          r_next.rdata[ioo_pkg::STAT_RUN_BIT] =
            (r_reg.state == ioo_pkg::ST_RUN);
          r_next.rdata[ioo_pkg::STAT_IDX_BIT] = r_reg.indexed;
        end
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      r_reg            <= '0;
      r_reg.state      <= ioo_pkg::ST_SETTLE;
      r_reg.sfp        <= ioo_pkg::SFP_RESET;
      r_reg.bank       <= ioo_pkg::BANK_RESET;
      r_reg.dest_w     <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign ADDR_VALID = r_reg.addr_valid;
  assign DATA_ADDR  = r_reg.data_addr;
  assign INDEXED    = r_reg.indexed;
  assign DEST_W     = r_reg.dest_w;
  assign DEST_FILE  = r_reg.dest_file;
  assign WB_DAT_O   = r_reg.rdata;
  assign WB_ACK_O   = r_reg.ack;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_literal_bank: assert property (
    DEC_VALID && !r_reg.ext_en && DEC_ACCESS
    |=> DATA_ADDR == {$past(r_reg.bank), $past(DEC_FILE)} && !INDEXED)
    else $error("banked literal address wrong");

  a_literal_access: assert property (
    DEC_VALID && !r_reg.ext_en && !DEC_ACCESS && DEC_FILE <= 8'h5f
    |=> DATA_ADDR == {4'h0, $past(DEC_FILE)})
    else $error("low access bank address wrong");

  a_indexed_sum: assert property (
    DEC_VALID && r_reg.ext_en && !DEC_ACCESS && DEC_FILE <= 8'h5f
    |=> INDEXED && DATA_ADDR == $past(r_reg.sfp) + {4'h0, $past(DEC_FILE)})
    else $error("indexed address not pointer plus offset");

  a_upper_literal: assert property (
    DEC_VALID && !DEC_ACCESS && DEC_FILE > 8'h5f
    |=> !INDEXED && DATA_ADDR == {4'hf, $past(DEC_FILE)})
    else $error("upper access bank not literal");

  a_every_decode: assert property (
    DEC_VALID && r_reg.state == ioo_pkg::ST_RUN
    |=> ADDR_VALID && INDEXED == ($past(r_reg.ext_en) &&
        !$past(DEC_ACCESS) && $past(DEC_FILE) <= 8'h5f))
    else $error("decode missed or mode wrong");

  a_zero_pointer: assert property (
    DEC_VALID && r_reg.sfp == 12'h000 && !DEC_ACCESS && DEC_FILE <= 8'h5f
    |=> DATA_ADDR == {4'h0, $past(DEC_FILE)})
    else $error("zero pointer not backward compatible");

  a_dest_kept: assert property (
    DEC_VALID && r_reg.ext_en && !DEC_ACCESS
    |=> DEST_FILE == $past(DEC_DEST))
    else $error("destination changed in indexed mode");

  a_dest_steer: assert property (
    ADDR_VALID |-> DEST_W == !$past(DEC_DEST) &&
    DEST_FILE == $past(DEC_DEST))
    else $error("destination steering wrong");

  a_static_cfg: assert property (
    r_reg.state == ioo_pkg::ST_RUN |=> $stable(r_reg.ext_en) ##1
    $stable(r_reg.ext_en))
    else $error("extension enable changed while running");
endmodule : ioo_operand_decode
`default_nettype wire

/* File: testbench/ioo_operand_decode_tb_top.sv */
// Self-checking bench for the indexed offset operand decoder
`default_nettype none
module ioo_operand_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic        ext;
    logic [11:0] sfp;
    logic [3:0]  bank;
    logic [7:0]  file;
    logic        acc;
    logic        dest;
    logic [11:0] addr;
    logic        idx;
  } ioo_row_t;
  // ----------------------------------------------------------------
  // Cases: ext, pointer, bank, field, access, dest, address, indexed
  // ----------------------------------------------------------------
  localparam ioo_row_t ROWS [9] = '{
    '{1'b0, 12'h100, 4'h3, 8'h10, 1'b0, 1'b1, 12'h010, 1'b0},
    '{1'b0, 12'h100, 4'h3, 8'h10, 1'b1, 1'b0, 12'h310, 1'b0},
    '{1'b0, 12'h100, 4'h3, 8'h80, 1'b0, 1'b1, 12'hf80, 1'b0},
    '{1'b1, 12'h100, 4'h3, 8'h10, 1'b0, 1'b0, 12'h110, 1'b1},
    '{1'b1, 12'h100, 4'h3, 8'h5f, 1'b0, 1'b1, 12'h15f, 1'b1},
    '{1'b1, 12'h100, 4'h3, 8'h60, 1'b0, 1'b1, 12'hf60, 1'b0},
    '{1'b1, 12'h100, 4'h5, 8'h10, 1'b1, 1'b1, 12'h510, 1'b0},
    '{1'b1, 12'hfff, 4'h5, 8'h5f, 1'b0, 1'b0, 12'h05e, 1'b1},
    '{1'b1, 12'h000, 4'h5, 8'h20, 1'b0, 1'b1, 12'h020, 1'b1}};
  logic        CLK, RST_N, CFG_EXT_EN, DEC_VALID, DEC_ACCESS, DEC_DEST;
  logic [7:0]  DEC_FILE, WB_ADR_I;
  logic        ADDR_VALID, INDEXED, DEST_W, DEST_FILE;
  logic [11:0] DATA_ADDR;
  logic        WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, rd;
  int          n_fail, total_checks;
  ioo_operand_decode u_dut (.CLK(CLK), .RST_N(RST_N),
    .CFG_EXT_EN(CFG_EXT_EN), .DEC_VALID(DEC_VALID), .DEC_FILE(DEC_FILE),
    .DEC_ACCESS(DEC_ACCESS), .DEC_DEST(DEC_DEST), .ADDR_VALID(ADDR_VALID),
    .DATA_ADDR(DATA_ADDR), .INDEXED(INDEXED), .DEST_W(DEST_W),
    .DEST_FILE(DEST_FILE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O));
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val
  // ----------------------------------------------------------------
  // Classic Wishbone single cycle, waits for ack with no bound of its own
  // ----------------------------------------------------------------
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    WB_SEL_I <= s;
    // No bound of its own; ack ends this wait, else the watchdog
    do begin
      @(posedge CLK);
    end while (WB_ACK_O !== 1'b1);
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I  <= 1'b0;
    // Ack must be a single-cycle pulse
    @(posedge CLK);
    check_val({31'h0, WB_ACK_O}, 32'h0);
  endtask : wb
  task automatic dec(input logic [7:0] f, input logic a, input logic d,
                     input logic v, input logic [11:0] ea, input logic ei);
    @(posedge CLK);
    DEC_VALID  <= 1'b1;
    DEC_FILE   <= f;
    DEC_ACCESS <= a;
    DEC_DEST   <= d;
    @(posedge CLK);
    DEC_VALID <= 1'b0;
    #1;
    check_val({31'h0, ADDR_VALID}, {31'h0, v});
    check_val({20'h0, DATA_ADDR}, {20'h0, ea});
    check_val({31'h0, INDEXED}, {31'h0, ei});
    check_val({30'h0, DEST_W, DEST_FILE}, {30'h0, ~d, d});
  endtask : dec
  task automatic do_reset(input logic ext);
    @(posedge CLK);
    RST_N      <= 1'b0;
    CFG_EXT_EN <= ext;
    repeat (8) @(posedge CLK);
    // Release on the edge; outputs still show the reset values after it
    RST_N <= 1'b1;
    #1;
    check_val({DEST_W, DEST_FILE, INDEXED, ADDR_VALID, DATA_ADDR},
              {1'b1, 1'b0, 1'b0, 1'b0, 12'h000});
    dec(8'h10, 1'b0, 1'b1, 1'b0, 12'h010, 1'b0);
    repeat (6) @(posedge CLK);
    wb(1'b0, ioo_pkg::SFP_OFFSET, 32'h0, 4'hf);
    check_val(rd, {20'h0, ioo_pkg::SFP_RESET});
    wb(1'b0, ioo_pkg::STATUS_OFFSET, 32'h0, 4'hf);
    check_val(rd & 32'h3, {30'h0, 1'b1, ext});
    $display("test reset ext=%0d done", ext);
  endtask : do_reset
  initial begin
    #200us;
    n_fail++;
    print_verdict();
  end
  initial begin
    RST_N = 1'b0; CFG_EXT_EN = 1'b0; DEC_VALID = 1'b0; DEC_FILE = 8'h00;
    DEC_ACCESS = 1'b0; DEC_DEST = 1'b0; WB_CYC_I = 1'b0; WB_STB_I = 1'b0;
    WB_WE_I = 1'b0; WB_ADR_I = 8'h00; WB_SEL_I = 4'h0; WB_DAT_I = 32'h0;
    n_fail = 0; total_checks = 0;
    do_reset(1'b0);
    foreach (ROWS[i]) begin
      if (i == 3) do_reset(1'b1);
      wb(1'b1, ioo_pkg::SFP_OFFSET, {20'h0, ROWS[i].sfp}, 4'h3);
      wb(1'b1, ioo_pkg::BANK_OFFSET, {28'h0, ROWS[i].bank}, 4'h1);
      dec(ROWS[i].file, ROWS[i].acc, ROWS[i].dest, 1'b1,
          ROWS[i].addr, ROWS[i].idx);
      wb(1'b0, ioo_pkg::STATUS_OFFSET, 32'h0, 4'hf);
      check_val(rd & 32'h4, {29'h0, ROWS[i].idx, 2'h0});
      $display("test row %0d done", i);
    end
    // Back to back decodes with the request held high
    @(posedge CLK);
    DEC_VALID  <= 1'b1;
    DEC_FILE   <= 8'h05;
    DEC_ACCESS <= 1'b0;
    @(posedge CLK);
    DEC_FILE <= 8'h61;
    #1;
    check_val({19'h0, ADDR_VALID, DATA_ADDR}, {19'h0, 1'b1, 12'h005});
    @(posedge CLK);
    DEC_VALID <= 1'b0;
    #1;
    check_val({19'h0, INDEXED, DATA_ADDR}, {19'h0, 1'b0, 12'hf61});
    $display("test back to back done");
    // Unmapped place and read-only status
    wb(1'b1, 8'h0c, 32'hffff_ffff, 4'hf);
    wb(1'b0, 8'h0c, 32'h0, 4'hf);
    check_val(rd, 32'h0);
    wb(1'b1, ioo_pkg::STATUS_OFFSET, 32'h0, 4'hf);
    wb(1'b0, ioo_pkg::STATUS_OFFSET, 32'h0, 4'hf);
    check_val(rd & 32'h3, 32'h3);
    $display("test registers done");
    print_verdict();
  end
endmodule : ioo_operand_decode_tb_top
`default_nettype wire
